// ===== logic/rtps_core.v
`include "rtps_defs.vh"
`timescale 1ns/1ns
module rtps_core #(
  parameter RETAIN_CYC = `RTPS_RETAIN_CYC
) (
  // clock and power-on reset
  input  wire                      i_core_clk,
  input  wire                      i_nrst,
  // field presence from the rectifier (asynchronous)
  input  wire                      i_field_on,
  // decoded command strobe from the forward-link decoder
  input  wire                      i_cmd_valid,
  input  wire [`RTPS_CMD_W-1:0]    i_cmd_op,
  input  wire                      i_cmp_mode,
  input  wire                      i_uid_match,
  input  wire                      i_mem_match,
  // memory access requests
  output reg                       o_mem_rd,
  output reg                       o_mem_wr,
  // reply request to the backscatter modulator
  output reg                       o_reply,
  // state view
  output reg  [`RTPS_ST_W-1:0]     o_state,
  output reg                       o_powered,
  output reg                       o_sticky
);

  // synchronised field and retained flag
  wire                   field_sync;
  wire                   sticky_now;
  // protocol state and power tracking
  reg  [`RTPS_ST_W-1:0]  state_reg;
  reg  [`RTPS_ST_W-1:0]  state_next;
  reg                    powered_reg;
  // flag control and select criterion
  reg                    sticky_set;
  reg                    sticky_clr;
  reg                    sel_hit;
  // command classes and gating
  reg                    is_sel;
  reg                    is_usel;
  reg                    is_init;
  reg                    is_rd;
  reg                    is_drd;
  reg                    is_wr;
  reg                    is_lock;
  reg                    cmd_active;
  reg                    cmd_take;
  // next values of the registered outputs
  reg                    rd_next;
  reg                    wr_next;
  reg                    reply_next;

  // field level crosses in through two flops
  // the field edge is slow, so two flops of latency cost nothing
  rtps_sync2 u_field_sync (
    .i_core_clk (i_core_clk),
    .i_nrst     (i_nrst),
    .i_async    (i_field_on),
    .o_sync     (field_sync)
  );

  // not on reset
  // decay counts only unpowered cycles; a short null keeps the flag
  rtps_retain #(
    .RETAIN_CYC (RETAIN_CYC)
  ) u_sticky (
    .i_core_clk (i_core_clk),
    .i_powered  (powered_reg),
    .i_set      (sticky_set),
    .i_clear    (sticky_clr),
    .o_flag     (sticky_now)
  );

  // select criterion: memory compare or flag compare
  always @* begin
    sel_hit = 1'b0;
    case (i_cmd_op)
      `RTPS_CMD_SEL_MEM, `RTPS_CMD_USEL_MEM: begin
        sel_hit = i_mem_match;
      end
      `RTPS_CMD_SEL_FLAG, `RTPS_CMD_USEL_FLAG: begin
        sel_hit = (i_cmp_mode == `RTPS_CMP_EQ) ? sticky_now : ~sticky_now;
      end
      default: begin
        sel_hit = 1'b0;
      end
    endcase
  end

  // decoded forward link
  // opcode classes; the forward-link decoder has already stripped the
  // Manchester coding and checked the frame, so one strobe is one command
  // classes are kept one-hot so the state table below stays readable
  always @* begin
    is_sel  = 1'b0;
    is_usel = 1'b0;
    is_init = 1'b0;
    is_rd   = 1'b0;
    is_drd  = 1'b0;
    is_wr   = 1'b0;
    is_lock = 1'b0;
    case (i_cmd_op)
      `RTPS_CMD_SEL_MEM, `RTPS_CMD_SEL_FLAG: begin
        is_sel = 1'b1;
      end
      `RTPS_CMD_USEL_MEM, `RTPS_CMD_USEL_FLAG: begin
        is_usel = 1'b1;
      end
      `RTPS_CMD_INIT: begin
        is_init = 1'b1;
      end
      `RTPS_CMD_READ: begin
        is_rd = 1'b1;
      end
      `RTPS_CMD_DATA_READ: begin
        is_drd = 1'b1;
      end
      `RTPS_CMD_WRITE: begin
        is_wr = 1'b1;
      end
      `RTPS_CMD_LOCK: begin
        is_lock = 1'b1;
      end
      default: begin
        is_init = 1'b0;
      end
    endcase
  end

  // state activity table
  // command classes the present state listens to; unknown opcodes are
  // never active, so a stray code from the decoder cannot move the state
  // and an inactive command gets no reply pulse either
  always @* begin
    cmd_active = 1'b0;
    case (state_reg)
      `RTPS_ST_READY: begin
        cmd_active = is_sel | is_init | is_rd | is_wr;
      end
      `RTPS_ST_ARB: begin
        cmd_active = is_sel | is_usel | is_init | is_rd | is_drd | is_wr;
      end
      `RTPS_ST_KNOWN: begin
        cmd_active = is_init | is_rd | is_drd | is_wr | is_lock;
      end
      default: begin
        cmd_active = 1'b0;
      end
    endcase
  end

  // taken only while powered; strobes during the power-up settle are lost
  always @* begin
    cmd_take = i_cmd_valid & powered_reg & cmd_active;
  end

  // next state; a command that is not taken leaves everything alone
  always @* begin
    state_next = state_reg;
    sticky_set = 1'b0;
    // commands never clear the flag; only a long null lets it decay
    sticky_clr = 1'b0;
    rd_next    = 1'b0;
    wr_next    = 1'b0;
    reply_next = 1'b0;
    // three states
    // a code outside the three cannot come from reset; if one ever did,
    // fall back to ready rather than sit with every command inactive
    if (state_reg != `RTPS_ST_READY && state_reg != `RTPS_ST_ARB
        && state_reg != `RTPS_ST_KNOWN) begin
      state_next = `RTPS_ST_READY;
    end else if (cmd_take && is_init) begin
      state_next = `RTPS_ST_READY;
    end else if (cmd_take) begin
      case (state_reg)
        `RTPS_ST_READY: begin
          if (is_sel && sel_hit) begin
            state_next = `RTPS_ST_ARB;
          end else if ((is_rd || is_wr) && i_uid_match) begin
            state_next = `RTPS_ST_KNOWN;
            rd_next    = is_rd;
            wr_next    = is_wr;
            reply_next = 1'b1;
          end
        end
        `RTPS_ST_ARB: begin
          // a repeated matching select keeps the tag in the round and answers
          if (is_sel && sel_hit) begin
            reply_next = 1'b1;
          end else if (is_usel && sel_hit) begin
            state_next = `RTPS_ST_READY;
          end else if ((is_drd || is_rd) && i_uid_match) begin
            state_next = `RTPS_ST_KNOWN;
            sticky_set = 1'b1;
            rd_next    = 1'b1;
            reply_next = 1'b1;
          end else if (is_wr && i_uid_match) begin
            state_next = `RTPS_ST_KNOWN;
            wr_next    = 1'b1;
            reply_next = 1'b1;
          end
        end
        `RTPS_ST_KNOWN: begin
          if (i_uid_match) begin
            rd_next    = is_rd | is_drd;
            wr_next    = is_wr | is_lock;
            reply_next = 1'b1;
          end
        end
        default: begin
          state_next = `RTPS_ST_READY;
        end
      endcase
    end
  end

  // state and power tracking; reset and field loss both give ready
  always @(posedge i_core_clk) begin
    if (!i_nrst) begin
      state_reg   <= `RTPS_ST_READY;
      powered_reg <= 1'b0;
    end else if (!field_sync) begin
      state_reg   <= `RTPS_ST_READY;
      powered_reg <= 1'b0;
    end else begin
      state_reg   <= state_next;
      powered_reg <= 1'b1;
    end
  end

  // request pulses; next values default low, so each lasts one cycle
  // a field drop kills a pending pulse: no power is left to act on it
  always @(posedge i_core_clk) begin
    if (!i_nrst) begin
      o_mem_rd <= 1'b0;
      o_mem_wr <= 1'b0;
      o_reply  <= 1'b0;
    end else if (!field_sync) begin
      o_mem_rd <= 1'b0;
      o_mem_wr <= 1'b0;
      o_reply  <= 1'b0;
    end else begin
      o_mem_rd <= rd_next;
      o_mem_wr <= wr_next;
      o_reply  <= reply_next;
    end
  end

  // state view; mirrors state_reg so the output comes from its own flop
  always @(posedge i_core_clk) begin
    if (!i_nrst) begin
      o_state   <= `RTPS_ST_READY;
      o_powered <= 1'b0;
      // the flag outlives reset, so its view does too
      o_sticky  <= sticky_now;
    end else if (!field_sync) begin
      o_state   <= `RTPS_ST_READY;
      o_powered <= 1'b0;
      o_sticky  <= sticky_now;
    end else begin
      o_state   <= state_next;
      o_powered <= 1'b1;
      // include a set landing this edge so the view never lags it
      o_sticky  <= sticky_now | sticky_set;
    end
  end

endmodule

// ===== logic/rtps_defs.vh
`ifndef RTPS_DEFS_VH
`define RTPS_DEFS_VH

// protocol state codes, one-hot
`define RTPS_ST_READY      3'h1
`define RTPS_ST_ARB        3'h2
`define RTPS_ST_KNOWN      3'h4
`define RTPS_ST_W          3

// command opcodes as delivered by the command decoder
`define RTPS_CMD_W         4
`define RTPS_CMD_SEL_MEM   4'h1
`define RTPS_CMD_SEL_FLAG  4'h2
`define RTPS_CMD_USEL_MEM  4'h3
`define RTPS_CMD_USEL_FLAG 4'h4
`define RTPS_CMD_INIT      4'h5
`define RTPS_CMD_READ      4'h6
`define RTPS_CMD_DATA_READ 4'h7
`define RTPS_CMD_WRITE     4'h8
`define RTPS_CMD_LOCK      4'h9

// compare modes of a select: equal, not equal
`define RTPS_CMP_EQ        1'h0
`define RTPS_CMP_NE        1'h1

// sticky flag retention in milliseconds at 250 MHz (4 ns)
`define RTPS_RETAIN_MS     2000
`define RTPS_CLK_HZ        250000000
`define RTPS_RETAIN_CYC    (`RTPS_RETAIN_MS * (`RTPS_CLK_HZ / 1000))

`endif

// ===== logic/rtps_sync2.v
`timescale 1ns/1ns
// two-stage synchroniser for a level from outside the clock domain
module rtps_sync2 (
  // clock and reset
  input  wire i_core_clk,
  input  wire i_nrst,
  // level in and out
  input  wire i_async,
  output reg  o_sync
);

  reg meta_reg;

  // first stage feeds only the second
  always @(posedge i_core_clk) begin
    if (!i_nrst) begin
      meta_reg <= 1'b0;
      o_sync   <= 1'b0;
    end else begin
      meta_reg <= i_async;
      o_sync   <= meta_reg;
    end
  end

endmodule

// ===== logic/rtps_retain.v
`timescale 1ns/1ns
// retention cell for the sticky selected flag; no power-on reset input
module rtps_retain #(
  parameter RETAIN_CYC = 32'h1DCD_6500
) (
  // clock
  input  wire i_core_clk,
  // control
  input  wire i_powered,
  input  wire i_set,
  input  wire i_clear,
  // state
  output reg  o_flag
);

  reg [31:0] decay_reg;

  initial o_flag = 1'b0;
  initial decay_reg = 32'h0000_0000;

  // flag decays only after a null lasting the whole retention time
  always @(posedge i_core_clk) begin
    if (i_set) begin
      o_flag    <= 1'b1;
      decay_reg <= 32'h0000_0000;
    end else if (i_clear) begin
      o_flag    <= 1'b0;
      decay_reg <= 32'h0000_0000;
    end else if (i_powered) begin
      decay_reg <= 32'h0000_0000;
    end else if (o_flag) begin
      if (decay_reg >= RETAIN_CYC - 32'd1) begin
        o_flag    <= 1'b0;
        decay_reg <= 32'h0000_0000;
      end else begin
        decay_reg <= decay_reg + 32'd1;
      end
    end
  end

endmodule

// ===== testbench/rtps_core_assertions.sv
`include "rtps_defs.vh"
`timescale 1ns/1ns
// protocol state checker on the ports of rtps_core
module rtps_chk (
  // clock and reset
  input wire       i_core_clk,
  input wire       i_nrst,
  // decoded command
  input wire       i_cmd_valid,
  input wire [3:0] i_cmd_op,
  input wire       i_cmp_mode,
  input wire       i_uid_match,
  input wire       i_mem_match,
  // outputs
  input wire       o_mem_rd,
  input wire       o_mem_wr,
  input wire       o_reply,
  input wire [2:0] o_state,
  input wire       o_powered,
  input wire       o_sticky
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  // a command counts only while powered
  wire tk = i_cmd_valid && o_powered;
  wire rdy = o_state == `RTPS_ST_READY;
  wire arb = o_state == `RTPS_ST_ARB;
  one_hot_a: assert property ($onehot(o_state)) else $error("state not one-hot");
  reset_ready_a: assert property ($rose(i_nrst) |-> rdy) else $error("not ready at reset");
  unpowered_ready_a: assert property (!o_powered |-> rdy) else $error("active unpowered");
  select_arb_a: assert property (
    tk && rdy && i_cmd_op == `RTPS_CMD_SEL_MEM && i_mem_match |=> arb)
    else $error("select missed");
  deselect_ready_a: assert property (
    tk && arb && i_cmd_op == `RTPS_CMD_USEL_MEM && i_mem_match |=> rdy)
    else $error("deselect missed");
  arb_read_a: assert property (
    tk && arb && i_cmd_op == `RTPS_CMD_DATA_READ && i_uid_match
    |=> o_state == `RTPS_ST_KNOWN && o_sticky && o_mem_rd && o_reply)
    else $error("arb read");
  plain_read_a: assert property (
    tk && i_cmd_op == `RTPS_CMD_READ && i_uid_match |=> o_state == `RTPS_ST_KNOWN)
    else $error("read missed");
  init_ready_a: assert property (tk && i_cmd_op == `RTPS_CMD_INIT |=> rdy) else $error("init");
  idle_ignore_a: assert property (
    tk && rdy && i_cmd_op == `RTPS_CMD_DATA_READ |=> rdy && !o_reply)
    else $error("ready took arb read");
  flag_select_a: assert property (
    tk && rdy && i_cmd_op == `RTPS_CMD_SEL_FLAG && (i_cmp_mode ^ o_sticky) |=> arb)
    else $error("flag select");
  flag_deselect_a: assert property (
    tk && arb && i_cmd_op == `RTPS_CMD_USEL_FLAG && (i_cmp_mode ^ o_sticky) |=> rdy)
    else $error("flag deselect missed");
  lock_write_a: assert property (
    tk && o_state == `RTPS_ST_KNOWN && i_cmd_op == `RTPS_CMD_LOCK && i_uid_match
    |=> o_mem_wr && o_reply && o_state == `RTPS_ST_KNOWN)
    else $error("lock missed");
  ready_lock_a: assert property (
    tk && rdy && i_cmd_op == `RTPS_CMD_LOCK |=> rdy && !o_mem_wr && !o_reply)
    else $error("ready took lock");
endmodule
bind rtps_core rtps_chk i_chk (.i_core_clk, .i_nrst, .i_cmd_valid, .i_cmd_op, .i_cmp_mode,
  .i_uid_match, .i_mem_match, .o_mem_rd, .o_mem_wr, .o_reply, .o_state, .o_powered, .o_sticky);

// ===== testbench/rtps_reader.sv
`timescale 1ns/1ns
// interrogator model: field level and decoded commands
module rtps_reader (
  // clock
  input wire       i_core_clk,
  // field and command
  output reg       o_field_on,
  output reg       o_cmd_valid,
  output reg [3:0] o_cmd_op,
  output reg       o_cmp_mode,
  output reg       o_uid_match,
  output reg       o_mem_match
);
  // quiet link at start; qualifiers follow the idle strobe
  initial begin
    o_field_on  = 1'h0;
    o_cmd_valid = 1'h0;
    {o_cmd_op, o_cmp_mode, o_uid_match, o_mem_match} = {7{o_cmd_valid}};
  end
  // field is either on or off
  task field(input on);
    o_field_on = on;
  endtask
  // one command per call; qualifiers scrambled once released
  task send(input [3:0] op, input m, input u, input k);
    begin
      @(posedge i_core_clk);
      #1;
      {o_cmd_valid, o_cmd_op, o_cmp_mode, o_uid_match, o_mem_match} = {1'h1, op, m, u, k};
      @(posedge i_core_clk);
      #1;
      o_cmd_valid = 1'h0;
      {o_cmd_op, o_cmp_mode, o_uid_match, o_mem_match} = ~{op, m, u, k};
    end
  endtask
endmodule

// ===== testbench/tb.sv
`include "rtps_defs.vh"
`timescale 1ns/1ns
// protocol state testbench
module tb;
  reg        i_core_clk = 1'h0;
  reg        i_nrst = 1'h0;
  wire       i_field_on, i_cmd_valid, i_cmp_mode, i_uid_match, i_mem_match;
  wire [3:0] i_cmd_op;
  wire       o_mem_rd, o_mem_wr, o_reply, o_powered, o_sticky;
  wire [2:0] o_state;
  integer    bad_count = 0;
  integer    comparisons = 0;
  integer    cycles = 0;
  // 250 MHz core clock
  always #2 i_core_clk = ~i_core_clk;
  rtps_reader i_rdr (.i_core_clk, .o_field_on(i_field_on), .o_cmd_valid(i_cmd_valid),
    .o_cmd_op(i_cmd_op), .o_cmp_mode(i_cmp_mode), .o_uid_match(i_uid_match),
    .o_mem_match(i_mem_match));
  // short retention keeps the null tests brief
  rtps_core #(.RETAIN_CYC(20)) i_dut (.i_core_clk, .i_nrst, .i_field_on, .i_cmd_valid,
    .i_cmd_op, .i_cmp_mode, .i_uid_match, .i_mem_match, .o_mem_rd, .o_mem_wr, .o_reply,
    .o_state, .o_powered, .o_sticky);
  task report_and_stop;
    begin
      $display("%0d mismatches in %0d comparisons", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task chk(input [3:0] s, input [3:0] e);
    begin
      comparisons = comparisons + 1;
      if (s !== e) begin
        bad_count = bad_count + 1;
        $display("Error at %0t: saw %h wanted %h", $time, s, e);
      end
    end
  endtask
  // hang guard, far above the planned run
  always @(posedge i_core_clk) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      bad_count = bad_count + 1;
      report_and_stop;
    end
  end
  task idle(input integer n);
    begin
      repeat (n) @(posedge i_core_clk);
      #1;
    end
  endtask
  task step(input [3:0] op, input m, input u, input k, input [2:0] st);
    begin
      i_rdr.send(op, m, u, k);
      chk(o_state, st);
    end
  endtask
  // power-up lands in ready and ignores arbitration reads
  task t_power_up;
    begin
      i_rdr.field(1'h1);
      idle(6);
      chk(o_state, `RTPS_ST_READY);
      step(`RTPS_CMD_DATA_READ, 1'h0, 1'h1, 1'h0, `RTPS_ST_READY);
      chk(o_reply, 1'h0);
      $display("test power_up done");
    end
  endtask
  // select, deselect, arbitration read, init, plain read, write
  task t_arb;
    begin
      step(`RTPS_CMD_SEL_MEM, 1'h0, 1'h0, 1'h0, `RTPS_ST_READY);
      step(`RTPS_CMD_SEL_MEM, 1'h0, 1'h0, 1'h1, `RTPS_ST_ARB);
      step(`RTPS_CMD_USEL_MEM, 1'h0, 1'h0, 1'h1, `RTPS_ST_READY);
      step(`RTPS_CMD_SEL_FLAG, `RTPS_CMP_NE, 1'h0, 1'h0, `RTPS_ST_ARB);
      step(`RTPS_CMD_DATA_READ, 1'h0, 1'h1, 1'h0, `RTPS_ST_KNOWN);
      chk({o_mem_rd, o_reply, o_sticky}, 4'h7);
      step(`RTPS_CMD_INIT, 1'h0, 1'h0, 1'h0, `RTPS_ST_READY);
      step(`RTPS_CMD_READ, 1'h0, 1'h0, 1'h0, `RTPS_ST_READY);
      step(`RTPS_CMD_WRITE, 1'h0, 1'h1, 1'h0, `RTPS_ST_KNOWN);
      chk(o_mem_wr, 1'h1);
      step(`RTPS_CMD_INIT, 1'h0, 1'h0, 1'h0, `RTPS_ST_READY);
      step(`RTPS_CMD_SEL_MEM, 1'h0, 1'h0, 1'h1, `RTPS_ST_ARB);
      step(`RTPS_CMD_READ, 1'h0, 1'h1, 1'h0, `RTPS_ST_KNOWN);
      step(`RTPS_CMD_LOCK, 1'h0, 1'h1, 1'h0, `RTPS_ST_KNOWN);
      chk(o_mem_wr, 1'h1);
      step(`RTPS_CMD_INIT, 1'h0, 1'h0, 1'h0, `RTPS_ST_READY);
      step(`RTPS_CMD_LOCK, 1'h0, 1'h1, 1'h0, `RTPS_ST_READY);
      chk({o_mem_wr, o_reply}, 4'h0);
      step(`RTPS_CMD_SEL_FLAG, `RTPS_CMP_EQ, 1'h0, 1'h0, `RTPS_ST_ARB);
      step(`RTPS_CMD_USEL_FLAG, `RTPS_CMP_EQ, 1'h0, 1'h0, `RTPS_ST_READY);
      $display("test arb done");
    end
  endtask
  // field nulls, sticky flag retention and reset
  task t_null;
    begin
      step(`RTPS_CMD_INIT, 1'h0, 1'h0, 1'h0, `RTPS_ST_READY);
      step(`RTPS_CMD_SEL_MEM, 1'h0, 1'h0, 1'h1, `RTPS_ST_ARB);
      i_rdr.field(1'h0);
      idle(6);
      chk({o_powered, o_state}, {1'h0, `RTPS_ST_READY});
      i_rdr.field(1'h1);
      idle(6);
      chk(o_sticky, 1'h1);
      step(`RTPS_CMD_DATA_READ, 1'h0, 1'h1, 1'h0, `RTPS_ST_READY);
      step(`RTPS_CMD_SEL_FLAG, `RTPS_CMP_NE, 1'h0, 1'h0, `RTPS_ST_READY);
      step(`RTPS_CMD_SEL_FLAG, `RTPS_CMP_EQ, 1'h0, 1'h0, `RTPS_ST_ARB);
      i_nrst = 1'h0;
      idle(2);
      i_nrst = 1'h1;
      idle(6);
      chk({o_sticky, o_state}, {1'h1, `RTPS_ST_READY});
      i_rdr.field(1'h0);
      idle(60);
      i_rdr.field(1'h1);
      idle(6);
      chk(o_sticky, 1'h0);
      $display("test null done");
    end
  endtask
  initial begin
    idle(16);
    i_nrst = 1'h1;
    t_power_up;
    t_arb;
    t_null;
    report_and_stop;
  end
endmodule
